// *** src/rslp_pkg.sv ***
package rslp_pkg;
    // register map
    localparam logic [7:0] REG_PWR_ADDR = 8'hAA;
    localparam logic [7:0] REG_OVR_ADDR = 8'hF2;
    localparam logic [7:0] PWR_RST_VAL = 8'h00;
    localparam logic [7:0] OVR_RST_VAL = 8'h00;
    localparam int PWR_LVL_MSB = 1;
    localparam int PWR_LVL_LSB = 0;
    localparam int PWR_SRST_BIT = 2;
    localparam int OVR_EN_BIT = 7;
    localparam logic [7:0] PWR_SRST_MASK = 8'h04;

    // power-save levels and drain line count
    localparam logic [1:0] LVL_FULL = 2'h0;
    localparam logic [1:0] LVL_STRAP = 2'h1;
    localparam logic [1:0] LVL_SLOW_BUS = 2'h3;
    localparam logic [1:0] DRAIN_LINES = 2'h2;

    // serial device write addresses chosen by the latched enable strap
    localparam logic [7:0] DEV_WR_ADDR_LO = 8'h86;
    localparam logic [7:0] DEV_WR_ADDR_HI = 8'h8E;

    // output pin groups, index into the enable vector
    localparam int PIN_PORT_A = 0;
    localparam int PIN_PORT_B = 1;
    localparam int PIN_LINE_REF = 2;
    localparam int PIN_VERT_REF = 3;
    localparam int PIN_FIELD = 4;
    localparam int PIN_ACT_VID = 5;
    localparam int PIN_PIX_CLK = 6;
    localparam int PIN_LLC = 7;
    localparam int PIN_LLC_HALF = 8;
    localparam int PIN_NUM = 9;

    // default-load table: register class, address, data
    typedef struct packed {
        logic is_ep;
        logic [7:0] addr;
        logic [11:0] data;
    } rslp_rom_s;
    localparam int INIT_LEN = 4;
    localparam logic [1:0] INIT_LAST = 2'h3;
    localparam rslp_rom_s INIT_ROM [INIT_LEN] = '{
        '{1'b0, 8'hAA, 12'h000},
        '{1'b0, 8'hF2, 12'h000},
        '{1'b1, 8'h20, 12'h000},
        '{1'b1, 8'h21, 12'h000}
    };

    typedef enum logic [1:0] {
        INIT_CLEAR = 2'b00,
        INIT_LOAD = 2'b01,
        INIT_RUN = 2'b10
    } rslp_init_e;

    typedef enum logic [1:0] {
        PWR_FULL = 2'b00,
        PWR_DRAIN = 2'b01,
        PWR_LOW = 2'b10
    } rslp_pwr_e;
endpackage

// *** src/rslp_ctrl.sv ***
`timescale 1ns/1ns
// Overview of operation
// - power-on clears all control and processor registers
// - then defaults load from internal ROM table
// - external reset tristates outputs, field pin pulled
// - reset release latches enable and field straps
// - field pin pull-down makes strap default low
// - field strap low tristates groups, high drives
// - enable pin high tristates ports; override re-enables
// - start-up always selects square-pixel NTSC format
// - sync scheduler off in low power until enabled
// - soft reset bit restarts init, keeps straps
// - inactive strap selects same low-power mode
// - manual power write cancels strap; strap unreadable
// - two-bit field picks normal or three levels
// - wait one full line before tristating (field strap low tristates at once)
// - registers kept and accessible; resume without reinit
// - full power until low-power logic takes effect
// - enable pin level selects device bus address
module rslp_ctrl (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_chip_clear_n,
    input wire logic i_oe_n_pin,
    input wire logic i_field_pin,
    input wire logic i_line_end,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic [rslp_pkg::PIN_NUM-1:0] o_pin_oe_n,
    output logic o_field_pulldown,
    output logic o_hsync_sched_en,
    output logic [1:0] o_power_level,
    output logic o_bus_slow_only,
    output logic o_init_busy,
    output logic o_fmt_default,
    output logic o_ep_clear,
    output logic o_ep_wr,
    output logic [7:0] o_ep_addr,
    output logic [11:0] o_ep_data,
    output logic [7:0] o_dev_wr_addr
);
    import rslp_pkg::*;

    logic [2:0] sync1;
    logic [2:0] sync2;
    logic clr_d;
    logic clr_s2;
    logic oe_s2;
    logic fld_s2;
    logic ext_rst;
    logic rise;
    logic strap_low;
    logic strap_asel;
    logic next_strap_low;
    logic next_strap_asel;
    rslp_init_e init_state;
    rslp_init_e next_init_state;
    logic [1:0] rom_idx;
    logic [1:0] next_rom_idx;
    logic [7:0] pwr_reg;
    logic [7:0] next_pwr_reg;
    logic [7:0] ovr_reg;
    logic [7:0] next_ovr_reg;
    logic next_ep_clear;
    logic next_ep_wr;
    logic [7:0] next_ep_addr;
    logic [11:0] next_ep_data;
    logic next_fmt_default;
    rslp_rom_s rom_entry;
    logic wr_pwr;
    logic soft_rst;
    rslp_pwr_e pstate;
    rslp_pwr_e next_pstate;
    logic [1:0] line_cnt;
    logic [1:0] next_line_cnt;
    logic [1:0] req_lvl;
    logic drive_all;
    logic pix_en;
    logic [PIN_NUM-1:0] next_oe_n;
    logic next_pulldown;
    logic next_sched_en;
    logic [1:0] next_level;
    logic [7:0] next_rdata;

    // pins and the reset line come from the board: two flops first
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            clr_d <= 1'b0;
        end else begin
            sync1 <= {i_chip_clear_n, i_oe_n_pin, i_field_pin};
            sync2 <= sync1;
            clr_d <= sync2[2];
        end
    end

    assign clr_s2 = sync2[2];
    assign oe_s2 = sync2[1];
    assign fld_s2 = sync2[0];
    assign ext_rst = ~clr_s2;
    assign rise = clr_s2 & ~clr_d;
    // a soft-reset write is a reset, not a power-mode selection
    assign wr_pwr = i_reg_wr & (i_reg_addr == REG_PWR_ADDR)
                    & (init_state == INIT_RUN) & ~ext_rst;
    assign soft_rst = wr_pwr & i_reg_wdata[PWR_SRST_BIT];

    // strap capture, clocked so the async reset only loads constants
    always_comb begin
        next_strap_low = strap_low;
        next_strap_asel = strap_asel;
        if (rise) begin
            next_strap_low = ~fld_s2;
            next_strap_asel = oe_s2;
        end else if (wr_pwr && !soft_rst) begin
            next_strap_low = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            strap_low <= 1'b0;
            strap_asel <= 1'b0;
        end else begin
            strap_low <= next_strap_low;
            strap_asel <= next_strap_asel;
        end
    end

    assign rom_entry = INIT_ROM[rom_idx];

    // clear, default load, then normal register access
    always_comb begin
        next_init_state = init_state;
        next_rom_idx = rom_idx;
        next_pwr_reg = pwr_reg;
        next_ovr_reg = ovr_reg;
        next_ep_clear = 1'b0;
        next_ep_wr = 1'b0;
        next_ep_addr = o_ep_addr;
        next_ep_data = o_ep_data;
        next_fmt_default = 1'b0;
        case (init_state)
            INIT_CLEAR: begin
                next_pwr_reg = PWR_RST_VAL;
                next_ovr_reg = OVR_RST_VAL;
                next_ep_clear = 1'b1;
                next_rom_idx = 2'h0;
                next_init_state = INIT_LOAD;
            end
            INIT_LOAD: begin
                if (rom_entry.is_ep) begin
                    next_ep_wr = 1'b1;
                    next_ep_addr = rom_entry.addr;
                    next_ep_data = rom_entry.data;
                end else if (rom_entry.addr == REG_PWR_ADDR) begin
                    next_pwr_reg = rom_entry.data[7:0] & ~PWR_SRST_MASK;
                end else if (rom_entry.addr == REG_OVR_ADDR) begin
                    next_ovr_reg = rom_entry.data[7:0];
                end
                if (rom_idx == INIT_LAST) begin
                    next_init_state = INIT_RUN;
                    next_fmt_default = 1'b1;
                end else begin
                    next_rom_idx = rom_idx + 2'h1;
                end
            end
            INIT_RUN: begin
                // writes stay open in every power level
                if (i_reg_wr && i_reg_addr == REG_OVR_ADDR) begin
                    next_ovr_reg = i_reg_wdata;
                end
                if (wr_pwr) begin
                    next_pwr_reg = i_reg_wdata & ~PWR_SRST_MASK;
                end
                if (soft_rst) begin
                    next_init_state = INIT_CLEAR;
                end
            end
            default: begin
                next_init_state = INIT_CLEAR;
            end
        endcase
        // held in clear for as long as the reset line is low
        if (ext_rst) begin
            next_init_state = INIT_CLEAR;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            init_state <= INIT_CLEAR;
            rom_idx <= 2'h0;
            pwr_reg <= PWR_RST_VAL;
            ovr_reg <= OVR_RST_VAL;
            o_ep_clear <= 1'b0;
            o_ep_wr <= 1'b0;
            o_ep_addr <= 8'h00;
            o_ep_data <= 12'h000;
            o_fmt_default <= 1'b0;
        end else begin
            init_state <= next_init_state;
            rom_idx <= next_rom_idx;
            pwr_reg <= next_pwr_reg;
            ovr_reg <= next_ovr_reg;
            o_ep_clear <= next_ep_clear;
            o_ep_wr <= next_ep_wr;
            o_ep_addr <= next_ep_addr;
            o_ep_data <= next_ep_data;
            o_fmt_default <= next_fmt_default;
        end
    end

    // the strap asks for the same level as a manual selection
    assign req_lvl = strap_low ? LVL_STRAP : pwr_reg[PWR_LVL_MSB:PWR_LVL_LSB];

    // power state: the current line is finished before going quiet
    always_comb begin
        next_pstate = pstate;
        next_line_cnt = line_cnt;
        case (pstate)
            PWR_FULL: begin
                if (req_lvl != LVL_FULL && init_state == INIT_RUN) begin
                    next_pstate = PWR_DRAIN;
                    next_line_cnt = 2'h0;
                end
            end
            PWR_DRAIN: begin
                // partial line plus one full line, so two line ends
                if (req_lvl == LVL_FULL) begin
                    next_pstate = PWR_FULL;
                end else if (i_line_end) begin
                    if (line_cnt == DRAIN_LINES - 2'h1) begin
                        next_pstate = PWR_LOW;
                    end else begin
                        next_line_cnt = line_cnt + 2'h1;
                    end
                end
            end
            PWR_LOW: begin
                if (req_lvl == LVL_FULL) begin
                    next_pstate = PWR_FULL;
                end
            end
            default: begin
                next_pstate = PWR_FULL;
            end
        endcase
        if (ext_rst) begin
            next_pstate = PWR_FULL;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pstate <= PWR_FULL;
            line_cnt <= 2'h0;
        end else begin
            pstate <= next_pstate;
            line_cnt <= next_line_cnt;
        end
    end

    assign drive_all = ~ext_rst & ~strap_low & (pstate != PWR_LOW);
    assign pix_en = drive_all & (~oe_s2 | ovr_reg[OVR_EN_BIT]);

    // pin enables, status and read data, all registered
    always_comb begin
        for (int i = 0; i < PIN_NUM; i++) begin
            next_oe_n[i] = ~drive_all;
        end
        next_oe_n[PIN_PORT_A] = ~pix_en;
        next_oe_n[PIN_PORT_B] = ~pix_en;
        // weak pull-down whenever the field pin is not driven
        next_pulldown = ext_rst | ~drive_all;
        next_sched_en = ~ext_rst & (pstate != PWR_LOW)
                        & (init_state == INIT_RUN);
        next_level = (pstate == PWR_LOW) ? req_lvl : LVL_FULL;
        case (i_reg_addr)
            // strap request never shows in the level field
            REG_PWR_ADDR: next_rdata = pwr_reg & ~PWR_SRST_MASK;
            REG_OVR_ADDR: next_rdata = ovr_reg;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pin_oe_n <= {PIN_NUM{1'b1}};
            o_field_pulldown <= 1'b1;
            o_hsync_sched_en <= 1'b0;
            o_power_level <= LVL_FULL;
            o_bus_slow_only <= 1'b0;
            o_init_busy <= 1'b1;
            o_reg_rdata <= 8'h00;
            o_dev_wr_addr <= DEV_WR_ADDR_LO;
        end else begin
            o_pin_oe_n <= next_oe_n;
            o_field_pulldown <= next_pulldown;
            o_hsync_sched_en <= next_sched_en;
            o_power_level <= next_level;
            o_bus_slow_only <= (next_level == LVL_SLOW_BUS);
            o_init_busy <= (next_init_state != INIT_RUN);
            o_reg_rdata <= next_rdata;
            o_dev_wr_addr <= next_strap_asel ? DEV_WR_ADDR_HI
                                             : DEV_WR_ADDR_LO;
        end
    end

    // checks
    sequence s_load;
        (init_state == INIT_LOAD) [*4] ##1 (init_state == INIT_RUN);
    endsequence

    sequence s_go_low;
        (pstate == PWR_LOW) ##1 o_pin_oe_n[PIN_PORT_A];
    endsequence

    AST_EXT_RST_TRISTATE: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        ext_rst |=> (&o_pin_oe_n) && o_field_pulldown)
        else $error("outputs driven during external reset");

    AST_STRAP_INACTIVE: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        (rise && !fld_s2) |-> ##2 o_pin_oe_n[PIN_LLC]
            && o_pin_oe_n[PIN_LINE_REF])
        else $error("inactive strap left outputs driven");

    AST_ADDR_SELECT: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        rise |=> o_dev_wr_addr == ($past(oe_s2) ? DEV_WR_ADDR_HI
                                                : DEV_WR_ADDR_LO))
        else $error("device address not taken from strap");

    AST_INIT_SEQ: assert property (@(posedge i_clk)
        disable iff (!i_nrst || ext_rst)
        (init_state == INIT_CLEAR) |=> s_load)
        else $error("default load sequence broken");

    AST_CLEAR_REGS: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        (init_state == INIT_CLEAR) |=> pwr_reg == PWR_RST_VAL
            && ovr_reg == OVR_RST_VAL && o_ep_clear)
        else $error("registers not cleared");

    AST_SOFT_RESET: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        (soft_rst && !rise) |=> init_state == INIT_CLEAR
            && strap_low == $past(strap_low) && o_init_busy)
        else $error("soft reset wrong or resampled straps");

    AST_MANUAL_OVERRIDE: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        (wr_pwr && !soft_rst && !rise) |=> !strap_low)
        else $error("manual power write kept strap request");

    AST_NO_EARLY_LOW: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        (pstate == PWR_FULL) |=> pstate != PWR_LOW)
        else $error("low power entered without line wait");

    AST_LOW_AFTER_LINES: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        (pstate == PWR_DRAIN && i_line_end && !ext_rst
            && line_cnt == DRAIN_LINES - 2'h1 && req_lvl != LVL_FULL)
            |=> s_go_low)
        else $error("outputs not tristated after line wait");

    AST_PORT_DISABLE: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        (drive_all && oe_s2 && !ovr_reg[OVR_EN_BIT])
            |=> o_pin_oe_n[PIN_PORT_A] && o_pin_oe_n[PIN_PORT_B]
            && !o_pin_oe_n[PIN_LINE_REF])
        else $error("enable pin did not tristate ports");

    AST_RESUME: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        (pstate == PWR_LOW && req_lvl == LVL_FULL && !ext_rst
            && init_state == INIT_RUN && !soft_rst)
            |=> pstate == PWR_FULL && init_state == INIT_RUN
            ##1 o_hsync_sched_en)
        else $error("resume from low power reinitialised");

    AST_SCHED_OFF: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        (pstate == PWR_LOW) |=> !o_hsync_sched_en)
        else $error("sync scheduler running in low power");
endmodule

// *** dv/rslp_board.sv ***
`timescale 1ns/1ns
// board side: reset switch, strap resistors and free-running line timing
module rslp_board #(
    parameter int LINE_LEN = 16
) (
    input wire logic i_clk,
    input wire logic i_hold_rst,
    input wire logic i_oe_high,
    input wire logic i_field_pullup,
    input wire logic i_field_oe_n,
    output logic o_chip_clear_n,
    output logic o_oe_n_pin,
    output logic o_field_pin,
    output logic o_line_end
);
    logic [7:0] cnt;
    logic wiggle;
    // reset switch and address strap are plain levels
    assign o_chip_clear_n = ~i_hold_rst;
    assign o_oe_n_pin = i_oe_high;
    // undriven pin: pull-up if fitted, else the internal pull-down;
    // a driven pin carries video, so a changing pattern stands in
    assign o_field_pin = i_field_oe_n ? i_field_pullup : wiggle;
    // line ends keep coming; data users treat each one as the cut-off
    always @(posedge i_clk) begin
        cnt <= (cnt == 8'(LINE_LEN - 1)) ? 8'h00 : cnt + 8'h01;
        o_line_end <= (cnt == 8'(LINE_LEN - 1));
        wiggle <= ~wiggle;
    end
    initial begin
        cnt = 8'h00;
        wiggle = 1'b0;
        o_line_end = 1'b0;
    end
endmodule

// *** dv/rslp_ctrl_tb_top.sv ***
`timescale 1ns/1ns
module rslp_ctrl_tb_top;
    import rslp_pkg::*;
    localparam int LINE_LEN = 16;
    localparam int LIMIT = 5000;
    logic i_clk, i_nrst, hold_rst, oe_high, field_pu, i_reg_wr;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, o_ep_addr;
    logic [7:0] o_dev_wr_addr;
    logic chip_clear_n, oe_n_pin, field_pin, line_end;
    logic [PIN_NUM-1:0] o_pin_oe_n;
    logic [1:0] o_power_level;
    logic [11:0] o_ep_data;
    logic o_field_pulldown, o_hsync_sched_en, o_bus_slow_only;
    logic o_init_busy, o_fmt_default, o_ep_clear, o_ep_wr;
    int n_mismatch, compares, cycles, n_epwr, n_clr, n_fmt, waited;

    `define CHK(what, exp, got) begin compares++; \
        if ((got) !== (exp)) begin n_mismatch++; \
        $display("CHECK FAILED %s exp %0h got %0h", what, exp, got); \
        end end

    rslp_ctrl i_rslp_ctrl (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_chip_clear_n(chip_clear_n), .i_oe_n_pin(oe_n_pin),
        .i_field_pin(field_pin), .i_line_end(line_end),
        .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .o_pin_oe_n(o_pin_oe_n), .o_field_pulldown(o_field_pulldown),
        .o_hsync_sched_en(o_hsync_sched_en),
        .o_power_level(o_power_level), .o_bus_slow_only(o_bus_slow_only),
        .o_init_busy(o_init_busy), .o_fmt_default(o_fmt_default),
        .o_ep_clear(o_ep_clear), .o_ep_wr(o_ep_wr), .o_ep_addr(o_ep_addr),
        .o_ep_data(o_ep_data), .o_dev_wr_addr(o_dev_wr_addr));

    rslp_board #(.LINE_LEN(LINE_LEN)) i_rslp_board (.i_clk(i_clk),
        .i_hold_rst(hold_rst), .i_oe_high(oe_high),
        .i_field_pullup(field_pu),
        .i_field_oe_n(o_pin_oe_n[PIN_FIELD]),
        .o_chip_clear_n(chip_clear_n), .o_oe_n_pin(oe_n_pin),
        .o_field_pin(field_pin), .o_line_end(line_end));

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    // pulse counters for the init sequence, plus the hang guard
    always @(posedge i_clk) begin
        cycles++;
        if (o_ep_wr === 1'b1) n_epwr++;
        if (o_ep_clear === 1'b1) n_clr++;
        if (o_fmt_default === 1'b1) n_fmt++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic final_report();
        if (n_mismatch == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // one write strobe; low again before the next can start
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask

    // read data is registered, so look one edge after the address
    task automatic rd_chk(input string what, input logic [7:0] a,
            input logic [7:0] e);
        @(posedge i_clk);
        i_reg_addr <= a;
        tick(1);
        `CHK(what, e, o_reg_rdata)
    endtask

    task automatic wait_idle();
        tick(2);
        for (int k = 0; k < 60 && o_init_busy !== 1'b0; k++) tick(1);
        `CHK("init busy", 1'b0, o_init_busy)
    endtask

    // bounded wait; waited also shows how long the drain took
    task automatic wait_lvl(input logic [1:0] l);
        waited = 0;
        while (o_power_level !== l && waited < 4 * LINE_LEN) begin
            tick(1);
            waited++;
        end
    endtask

    task automatic init_chk();
        wait_idle();
        tick(6);
        `CHK("rom proc writes", 2, n_epwr)
        `CHK("proc clear", 1'b1, n_clr > 0)
        `CHK("format default", 1, n_fmt)
        `CHK("proc addr", INIT_ROM[INIT_LEN-1].addr, o_ep_addr)
        `CHK("proc data", INIT_ROM[INIT_LEN-1].data, o_ep_data)
        rd_chk("pwr reg", REG_PWR_ADDR, 8'h00);
        rd_chk("ovr reg", REG_OVR_ADDR, 8'h00);
    endtask

    // hold the reset switch eleven cycles (i_nrst is never pulled low here), then release with the given straps
    task automatic ext_reset(input logic oe, input logic pu);
        @(posedge i_clk);
        hold_rst <= 1'b1;
        oe_high <= oe;
        field_pu <= pu;
        tick(10);
        `CHK("oe in reset", {PIN_NUM{1'b1}}, o_pin_oe_n)
        `CHK("field pulldown", 1'b1, o_field_pulldown)
        n_epwr = 0;
        n_clr = 0;
        n_fmt = 0;
        @(posedge i_clk);
        hold_rst <= 1'b0;
        i_nrst <= 1'b1;
        init_chk();
    endtask

    initial begin
        i_nrst = 1'b0;
        hold_rst = 1'b1;
        oe_high = 1'b1;
        field_pu = 1'b1;
        i_reg_wr = 1'b0;
        i_reg_addr = 8'h00;
        i_reg_wdata = 8'h00;
        n_mismatch = 0;
        compares = 0;
        cycles = 0;
        // power-on: address strap high, outputs strapped active
        ext_reset(1'b1, 1'b1);
        `CHK("dev addr", DEV_WR_ADDR_HI, o_dev_wr_addr)
        `CHK("ports off", 9'h003, o_pin_oe_n)
        `CHK("level", LVL_FULL, o_power_level)
        `CHK("sched", 1'b1, o_hsync_sched_en)
        `CHK("pulldown off", 1'b0, o_field_pulldown)
        // override brings ports back though the pin stays high
        wr(REG_OVR_ADDR, 8'h80);
        tick(3);
        `CHK("ports on", 9'h000, o_pin_oe_n)
        rd_chk("ovr", REG_OVR_ADDR, 8'h80);
        // every level, then back to full power without reinit
        for (int l = 1; l < 4; l++) begin
            wr(REG_PWR_ADDR, 8'(l));
            tick(2);
            `CHK("still driving", 9'h000, o_pin_oe_n)
            wait_lvl(2'(l));
            `CHK("line wait", 1'b1, waited + 2 >= LINE_LEN)
            `CHK("low level", 2'(l), o_power_level)
            tick(1);
            `CHK("low off", {PIN_NUM{1'b1}}, o_pin_oe_n)
            `CHK("slow bus", l == 3, o_bus_slow_only)
            rd_chk("ovr kept", REG_OVR_ADDR, 8'h80);
            rd_chk("pwr rd", REG_PWR_ADDR, 8'(l));
            wr(REG_PWR_ADDR, 8'h00);
            tick(3);
            `CHK("resume", 9'h000, o_pin_oe_n)
            `CHK("full", LVL_FULL, o_power_level)
        end
        // soft reset after the address pin went low: straps held
        @(posedge i_clk);
        oe_high <= 1'b0;
        n_epwr = 0;
        n_clr = 0;
        n_fmt = 0;
        wr(REG_PWR_ADDR, PWR_SRST_MASK);
        init_chk();
        `CHK("addr kept", DEV_WR_ADDR_HI, o_dev_wr_addr)
        `CHK("driven", 9'h000, o_pin_oe_n)
        // field left to the pull-down: inactive low-power start
        ext_reset(1'b0, 1'b0);
        `CHK("dev addr lo", DEV_WR_ADDR_LO, o_dev_wr_addr)
        // line wait still running, so the level must read full
        `CHK("full first", LVL_FULL, o_power_level)
        wait_lvl(LVL_STRAP);
        tick(1);
        `CHK("strap low", LVL_STRAP, o_power_level)
        `CHK("all off", {PIN_NUM{1'b1}}, o_pin_oe_n)
        `CHK("pulldown on", 1'b1, o_field_pulldown)
        `CHK("sched off", 1'b0, o_hsync_sched_en)
        rd_chk("strap hidden", REG_PWR_ADDR, 8'h00);
        wr(REG_PWR_ADDR, 8'h00);
        tick(3);
        `CHK("manual full", LVL_FULL, o_power_level)
        `CHK("sched on", 1'b1, o_hsync_sched_en)
        `CHK("all on", 9'h000, o_pin_oe_n)
        final_report();
    end
endmodule
